// ===== src/ufs_pkg.sv
package ufs_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int WORDS = 512;
	localparam int TOTAL_BITS = 8192;
	localparam int SECTOR_BITS = 4096;
	localparam int SECTOR_BIT = 8;
	localparam logic [ADDR_W-1:0] ADDR_MAX = 9'h1ff;
	localparam logic [ADDR_W-1:0] SECT0_LAST = 9'h0ff;
	localparam logic [ADDR_W-1:0] SECT1_BASE = 9'h100;
	localparam logic [7:0] SECT_OFS_LAST = 8'hff;
	localparam logic [DATA_W-1:0] ERASED_WORD = 16'hffff;

	// clock rate and operation times
	localparam int CLK_MHZ = 20;
	localparam int PROG_TIME_NS = 1600;
	localparam int ERASE_TIME_NS = 500000;
	localparam int PROG_CYCLES = (PROG_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int ERASE_CYCLES = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int OP_CNT_W = 20;
	localparam int RING_DIV = 4;
	localparam int RING_CNT_W = 2;

	// register map
	localparam int AXI_AW = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [AXI_AW-1:0] REG_RDATA = 8'h08;
	localparam logic [AXI_AW-1:0] REG_SHIFT = 8'h0c;
	localparam int CTRL_RING_EN_BIT = 0;
	localparam int CTRL_ASRC_LSB = 4;
	localparam int CTRL_DSRC_LSB = 8;
	localparam int SRC_W = 3;
	localparam logic [31:0] CTRL_MASK = 32'h0000_0771;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_NEMPTY_BIT = 1;
	localparam int STATUS_FULL_BIT = 2;
	localparam int STATUS_PEND_BIT = 3;
	localparam int STATUS_ADDR_LSB = 16;
	localparam int RDATA_VALID_BIT = 31;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int FIFO_DEPTH = 32;

	// synchronised pin vector layout
	localparam int PIN_ACLK = 0;
	localparam int PIN_ASEL = 1;
	localparam int PIN_ADIN = 2;
	localparam int PIN_DCLK = 3;
	localparam int PIN_DSEL = 4;
	localparam int PIN_DDIN = 5;
	localparam int PIN_PROG = 6;
	localparam int PIN_ERASE = 7;
	localparam int PIN_N = 8;

	typedef enum logic [1:0] {UFS_IDLE, UFS_PROG, UFS_ERASE_WAIT, UFS_ERASE_CLR} ufs_op_e;
endpackage

// ===== src/ufs_fifo.sv
`timescale 1ns/10ps
module ufs_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [PW-1:0] LAST_PTR = PW'(DEPTH - 1);

	typedef struct packed {
		logic [PW-1:0] wptr;
		logic [PW-1:0] rptr;
		logic [CW-1:0] count;
	} ufs_fifo_s;

	ufs_fifo_s q;
	ufs_fifo_s d;
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic push;
	logic pop;

	assign in_ready = q.count != FULL_CNT;
	assign out_valid = q.count != '0;
	assign out_data = mem[q.rptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		d = q;
		if (push)
		begin
			d.wptr = (q.wptr == LAST_PTR) ? '0 : q.wptr + 1'b1;
		end
		if (pop)
		begin
			d.rptr = (q.rptr == LAST_PTR) ? '0 : q.rptr + 1'b1;
		end
		if (push && !pop)
		begin
			d.count = q.count + 1'b1;
		end
		else if (pop && !push)
		begin
			d.count = q.count - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end

	always_ff @(posedge clk)
	begin
		if (push)
		begin
			mem[q.wptr] <= in_data;
		end
	end
endmodule

// ===== src/ufs_top.sv
`timescale 1ns/10ps
module ufs_top
	import ufs_pkg::*;
#(
	parameter int PROG_CYC = ufs_pkg::PROG_CYCLES,
	parameter int ERASE_CYC = ufs_pkg::ERASE_CYCLES,
	parameter int FIFO_WORDS = ufs_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic address_shift_clock,
	input wire logic address_shift_select,
	input wire logic address_serial_in,
	input wire logic data_shift_clock,
	input wire logic data_shift_select,
	input wire logic data_serial_in,
	output logic data_serial_out,
	input wire logic program_req,
	input wire logic erase_req,
	output logic busy,
	input wire logic [3:0] global_clock_pins,
	output logic internal_ring_clock,
	input wire logic [ufs_pkg::AXI_AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ufs_pkg::AXI_AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import ufs_pkg::*;

	typedef struct packed {
		logic [RING_CNT_W-1:0] ring_cnt;
		logic ring_out;
		logic [PIN_N-1:0] s1;
		logic [PIN_N-1:0] s2;
		logic [PIN_N-1:0] prev;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dsr;
		logic load_pend;
		ufs_op_e op;
		logic [OP_CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] op_addr;
		logic [DATA_W-1:0] op_data;
		logic busy;
		logic [31:0] ctrl;
		logic aw_held;
		logic [AXI_AW-1:0] awaddr;
		logic w_held;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ufs_state_s;

	ufs_state_s q;
	ufs_state_s d;
	logic [DATA_W-1:0] mem [0:WORDS-1];
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] rd_word;
	logic [PIN_N-1:0] pins;
	logic [PIN_N-1:0] rise;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [DATA_W-1:0] fifo_out_data;
	logic ar_take;

	// routing when the source is 0 or out of range, global line n-1 for 1..4
	function automatic logic pick_src(input logic [SRC_W-1:0] src, input logic route,
		input logic [3:0] gl);
		logic r;
		r = route;
		if (src >= 3'h1 && src <= 3'h4)
		begin
			r = gl[2'(src - 3'h1)];
		end
		return r;
	endfunction

	// muxing sits before the synchroniser so each line is sampled only once
	always_comb
	begin
		pins = '0;
		pins[PIN_ACLK] = pick_src(q.ctrl[CTRL_ASRC_LSB +: SRC_W], address_shift_clock,
			global_clock_pins);
		pins[PIN_DCLK] = pick_src(q.ctrl[CTRL_DSRC_LSB +: SRC_W], data_shift_clock,
			global_clock_pins);
		pins[PIN_ASEL] = address_shift_select;
		pins[PIN_ADIN] = address_serial_in;
		pins[PIN_DSEL] = data_shift_select;
		pins[PIN_DDIN] = data_serial_in;
		pins[PIN_PROG] = program_req;
		pins[PIN_ERASE] = erase_req;
	end

	assign rise = q.s2 & ~q.prev;
	assign rd_word = mem[q.addr];
	assign fifo_in_valid = q.load_pend && (q.op == UFS_IDLE);
	assign ar_take = s_axi_arvalid && q.arready;
	assign fifo_out_ready = ar_take && (s_axi_araddr == REG_RDATA);

	always_comb
	begin
		d = q;
		mem_we = 1'b0;
		mem_waddr = q.op_addr;
		mem_wdata = ERASED_WORD;

		// fixed divide by four, the ctrl ring enable bit only gates the output
		d.ring_cnt = q.ring_cnt + 1'b1;
		d.ring_out = q.ctrl[CTRL_RING_EN_BIT] && d.ring_cnt[RING_CNT_W-1];

		d.s1 = pins;
		d.s2 = q.s1;
		d.prev = q.s2;

		if (rise[PIN_ACLK])
		begin
			if (q.s2[PIN_ASEL])
			begin
				d.addr = {q.addr[ADDR_W-2:0], q.s2[PIN_ADIN]};
			end
			else
			begin
				// wraps from 1ff to 000
				d.addr = (q.addr == ADDR_MAX) ? '0 : q.addr + 1'b1;
			end
		end

		// a read load stalls while the fifo is full or an operation runs
		if (fifo_in_valid && fifo_in_ready)
		begin
			d.dsr = rd_word;
			d.load_pend = 1'b0;
		end
		if (rise[PIN_DCLK])
		begin
			if (q.s2[PIN_DSEL])
			begin
				d.dsr = {q.dsr[DATA_W-2:0], q.s2[PIN_DDIN]};
			end
			else
			begin
				d.load_pend = 1'b1;
			end
		end

		unique case (q.op)
			UFS_IDLE:
			begin
				// edge start: a held request cannot restart once busy falls
				if (rise[PIN_PROG])
				begin
					d.op = UFS_PROG;
					d.cnt = OP_CNT_W'(PROG_CYC - 1);
					d.op_addr = q.addr;
					d.op_data = q.dsr;
				end
				else if (rise[PIN_ERASE])
				begin
					d.op = UFS_ERASE_WAIT;
					d.cnt = OP_CNT_W'(ERASE_CYC - 1);
					d.op_addr = {q.addr[SECTOR_BIT], 8'h00};
				end
			end
			UFS_PROG:
			begin
				if (q.cnt == '0)
				begin
					// programming only clears bits, so an unerased word keeps its zeros
					mem_we = 1'b1;
					mem_wdata = mem[q.op_addr] & q.op_data;
					d.op = UFS_IDLE;
				end
				else
				begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			UFS_ERASE_WAIT:
			begin
				if (q.cnt == '0)
				begin
					d.op = UFS_ERASE_CLR;
				end
				else
				begin
					d.cnt = q.cnt - 1'b1;
				end
			end
			UFS_ERASE_CLR:
			begin
				// one word per cycle, sector bit never changes
				mem_we = 1'b1;
				d.op_addr = {q.op_addr[SECTOR_BIT], q.op_addr[SECTOR_BIT-1:0] + 8'h01};
				if (q.op_addr[SECTOR_BIT-1:0] == SECT_OFS_LAST)
				begin
					d.op = UFS_IDLE;
				end
			end
		endcase
		d.busy = d.op != UFS_IDLE;

		if (s_axi_awvalid && q.awready)
		begin
			d.aw_held = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready)
		begin
			d.w_held = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end
		if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
		end
		if (d.aw_held && d.w_held && !q.bvalid)
		begin
			d.aw_held = 1'b0;
			d.w_held = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = RESP_OKAY;
			unique case (d.awaddr)
				REG_CTRL:
				begin
					for (int i = 0; i < 4; i++)
					begin
						if (d.wstrb[i])
						begin
							d.ctrl[i*8 +: 8] = d.wdata[i*8 +: 8];
						end
					end
					d.ctrl = d.ctrl & CTRL_MASK;
				end
				REG_STATUS, REG_RDATA, REG_SHIFT:
				begin
					d.bresp = RESP_OKAY;
				end
				default:
				begin
					d.bresp = RESP_SLVERR;
				end
			endcase
		end
		d.awready = !d.aw_held && !d.bvalid;
		d.wready = !d.w_held && !d.bvalid;

		if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
		end
		if (ar_take)
		begin
			d.rvalid = 1'b1;
			d.rdata = '0;
			d.rresp = RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL:
				begin
					d.rdata = q.ctrl;
				end
				REG_STATUS:
				begin
					d.rdata[STATUS_BUSY_BIT] = q.busy;
					d.rdata[STATUS_NEMPTY_BIT] = fifo_out_valid;
					d.rdata[STATUS_FULL_BIT] = !fifo_in_ready;
					d.rdata[STATUS_PEND_BIT] = q.load_pend;
					d.rdata[STATUS_ADDR_LSB +: ADDR_W] = q.addr;
				end
				REG_RDATA:
				begin
					d.rdata[RDATA_VALID_BIT] = fifo_out_valid;
					d.rdata[DATA_W-1:0] = fifo_out_valid ? fifo_out_data : '0;
				end
				REG_SHIFT:
				begin
					d.rdata[DATA_W-1:0] = q.dsr;
				end
				default:
				begin
					d.rresp = RESP_SLVERR;
				end
			endcase
		end
		d.arready = !d.rvalid;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.awready <= 1'b1;
			q.wready <= 1'b1;
			q.arready <= 1'b1;
		end
		else
		begin
			q <= d;
		end
	end

	// no reset on the array: contents must survive like flash
	always_ff @(posedge clk)
	begin
		if (mem_we)
		begin
			mem[mem_waddr] <= mem_wdata;
		end
	end

	ufs_fifo #(
		.WIDTH(DATA_W),
		.DEPTH(FIFO_WORDS)
	) u_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(rd_word),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign data_serial_out = q.dsr[DATA_W-1];
	assign busy = q.busy;
	assign internal_ring_clock = q.ring_out;
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bresp = q.bresp;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_arready = q.arready;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign s_axi_rvalid = q.rvalid;
endmodule

// ===== testbench/ufs_top_asserts.sv
`timescale 1ns/10ps
module ufs_top_chk #(
	parameter int PROG_CYC = 32
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic program_req,
	input wire logic erase_req,
	input wire logic busy,
	input wire logic internal_ring_clock,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic [19:0] busy_cnt_q;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// length of the current busy run
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			busy_cnt_q <= 20'h0;
		else
			busy_cnt_q <= busy ? busy_cnt_q + 20'h1 : 20'h0;
	end
	property p_start;
		($rose(program_req) || $rose(erase_req)) && !busy |-> ##[1:6] busy;
	endproperty
	a_start: assert property (p_start) else $error("request left busy low");
	property p_len;
		$fell(busy) |-> busy_cnt_q >= PROG_CYC;
	endproperty
	a_len: assert property (p_len) else $error("busy dropped too early");
	property p_ring;
		$rose(internal_ring_clock) |=> (!$rose(internal_ring_clock)) [*3];
	endproperty
	a_ring: assert property (p_ring) else $error("ring output faster than a quarter");
	property p_bv;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_bv: assert property (p_bv) else $error("write response late");
	property p_bhold;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write taken during response");
	property p_bdone;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
	endproperty
	a_bdone: assert property (p_bdone) else $error("write response not retired");
	property p_rv;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	a_rv: assert property (p_rv) else $error("read response late");
	property p_rdone;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_rdone: assert property (p_rdone) else $error("read response not retired");
endmodule
bind ufs_top ufs_top_chk #(.PROG_CYC(PROG_CYC)) ufs_top_chk_i (.clk, .rst_b, .program_req,
	.erase_req, .busy, .internal_ring_clock, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rvalid, .s_axi_rready);

// ===== testbench/ufs_user_logic.sv
`timescale 1ns/10ps
module ufs_user_logic (
	input wire logic clk,
	input wire logic busy,
	output logic aclk,
	output logic asel,
	output logic ain,
	output logic dclk,
	output logic dsel,
	output logic din,
	output logic preq,
	output logic ereq
);
	initial {aclk, asel, ain, dclk, dsel, din, preq, ereq} = 8'h0;
	// four clocks per level so the pin synchronisers see every edge
	task automatic pulse(input bit is_a);
		if (is_a) aclk <= 1'b1; else dclk <= 1'b1;
		repeat (4) @(posedge clk);
		if (is_a) aclk <= 1'b0; else dclk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	task automatic set_addr(input logic [8:0] a);
		asel <= 1'b1;
		for (int i = 8; i >= 0; i--)
		begin
			ain <= a[i];
			pulse(1);
		end
		asel <= 1'b0;
		ain <= !a[0];
	endtask
	task automatic set_data(input logic [15:0] d);
		dsel <= 1'b1;
		for (int i = 15; i >= 0; i--)
		begin
			din <= d[i];
			pulse(0);
		end
		dsel <= 1'b0;
		din <= !d[0];
	endtask
	// request held until busy drops; n counts busy cycles, 0 if busy never came
	task automatic op(input bit er, output int n);
		n = 0;
		if (er) ereq <= 1'b1; else preq <= 1'b1;
		for (int i = 0; i < 3000 && (n == 0 || busy); i++)
		begin
			@(posedge clk);
			if (busy) n++;
		end
		preq <= 1'b0;
		ereq <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
endmodule

// ===== testbench/user_flash_store_serial_bench.sv
`timescale 1ns/10ps
module user_flash_store_serial_bench;
	import ufs_pkg::*;
	localparam int PGC = 4;
	localparam int ERC = 8;
	logic clk, rst_b, aclk, asel, ain, dclk, dsel, din, dout, preq, ereq, busy, ring;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [3:0] gclk, wstrb, strb_sel;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	int err_total = 0;
	int n_checks = 0;
	ufs_top #(.PROG_CYC(PGC), .ERASE_CYC(ERC)) ufs_top_i (.clk, .rst_b,
		.address_shift_clock(aclk), .address_shift_select(asel), .address_serial_in(ain),
		.data_shift_clock(dclk), .data_shift_select(dsel), .data_serial_in(din),
		.data_serial_out(dout), .program_req(preq), .erase_req(ereq), .busy,
		.global_clock_pins(gclk), .internal_ring_clock(ring), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	ufs_user_logic u (.clk, .busy, .aclk, .asel, .ain, .dclk, .dsel, .din, .preq, .ereq);
	always #25 clk = ~clk;
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// answer looked at only after an edge, so a stale valid from the last call is never taken
	// trailing edge keeps a lowered ready from being raised again in the same step
	task automatic wchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic done;
		done = 1'b0;
		awaddr <= a;
		wdata <= d;
		wstrb <= strb_sel;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge clk);
			done = bvalid;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk(done, 1'b1);
		chk(bresp, er);
		if (!done) wrap_up();
		@(posedge clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic done;
		done = 1'b0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50 && !done; i++)
		begin
			@(posedge clk);
			done = rvalid;
			if (arvalid && arready) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk(done, 1'b1);
		chk(rdata, ed);
		chk(rresp, er);
		if (!done) wrap_up();
		@(posedge clk);
	endtask
	task automatic prog(input logic [8:0] a, input logic [15:0] d);
		int n;
		u.set_addr(a);
		u.set_data(d);
		u.op(0, n);
		chk(n >= PGC && n < 100, 1);
	endtask
	task automatic era(input logic [8:0] a);
		int n;
		u.set_addr(a);
		u.op(1, n);
		chk(n >= ERC + 256 && n < 2000, 1);
	endtask
	task automatic load_chk(input logic [8:0] a, input logic [15:0] d);
		u.set_addr(a);
		u.pulse(0);
		rchk(REG_SHIFT, {16'h0, d}, RESP_OKAY);
		chk(dout, d[15]);
		rchk(REG_RDATA, {16'h8000, d}, RESP_OKAY);
	endtask
	task automatic t_regs;
		rchk(REG_CTRL, CTRL_RESET, RESP_OKAY);
		wchk(REG_CTRL, 32'hffff_ffff, RESP_OKAY);
		rchk(REG_CTRL, CTRL_MASK, RESP_OKAY);
		wchk(8'h10, 32'h0, RESP_SLVERR);
		rchk(8'h10, 32'h0, RESP_SLVERR);
		wchk(REG_STATUS, 32'hffff_ffff, RESP_OKAY);
		rchk(REG_STATUS, 32'h0, RESP_OKAY);
		$display("t_regs done");
	endtask
	task automatic t_ring;
		int n;
		logic p;
		for (int e = 1; e >= 0; e--)
		begin
			wchk(REG_CTRL, e, RESP_OKAY);
			n = 0;
			p = ring;
			repeat (40)
			begin
				@(posedge clk);
				if (ring && !p) n++;
				p = ring;
			end
			chk(n, e * 40 / RING_DIV);
		end
		wchk(REG_CTRL, CTRL_RESET, RESP_OKAY);
		$display("t_ring done");
	endtask
	// array is unknown after power-up, so both sectors are cleared first
	task automatic t_flash;
		era(9'h000);
		era(9'h100);
		load_chk(9'h0ff, ERASED_WORD);
		prog(9'h0ff, 16'h1234);
		prog(9'h100, 16'habcd);
		prog(9'h100, 16'h0ff0);
		load_chk(9'h0ff, 16'h1234);
		load_chk(9'h100, 16'h0bc0);
		era(9'h0ab);
		load_chk(9'h0ff, ERASED_WORD);
		load_chk(9'h100, 16'h0bc0);
		$display("t_flash done");
	endtask
	task automatic t_stream;
		logic [8:0] a;
		a = 9'h1fe;
		u.set_addr(a);
		repeat (3)
		begin
			u.pulse(0);
			rchk(REG_RDATA, 32'h8000_ffff, RESP_OKAY);
			rchk(REG_STATUS, {7'h0, a, 16'h0}, RESP_OKAY);
			u.pulse(1);
			a++;
		end
		rchk(REG_STATUS, 32'h0001_0000, RESP_OKAY);
		$display("t_stream done");
	endtask
	task automatic t_fifo;
		repeat (FIFO_DEPTH) u.pulse(0);
		rchk(REG_STATUS, 32'h0001_0006, RESP_OKAY);
		u.pulse(0);
		rchk(REG_STATUS, 32'h0001_000e, RESP_OKAY);
		repeat (FIFO_DEPTH + 1) rchk(REG_RDATA, 32'h8000_ffff, RESP_OKAY);
		rchk(REG_RDATA, 32'h0, RESP_OKAY);
		rchk(REG_STATUS, 32'h0001_0000, RESP_OKAY);
		$display("t_fifo done");
	endtask
	// byte lane 1 only: data clock from global line 2, routed data clock then ignored
	task automatic t_gclk;
		strb_sel = 4'h2;
		wchk(REG_CTRL, 32'hffff_03ff, RESP_OKAY);
		strb_sel = 4'hf;
		rchk(REG_CTRL, 32'h0000_0301, RESP_OKAY);
		u.pulse(0);
		rchk(REG_STATUS, 32'h0001_0000, RESP_OKAY);
		gclk <= 4'h4;
		repeat (4) @(posedge clk);
		gclk <= 4'h0;
		repeat (4) @(posedge clk);
		rchk(REG_RDATA, 32'h8000_ffff, RESP_OKAY);
		wchk(REG_CTRL, CTRL_RESET, RESP_OKAY);
		$display("t_gclk done");
	endtask
	initial
	begin
		clk = 1'b0;
		rst_b = 1'b0;
		{awvalid, wvalid, arvalid} = 3'h0;
		{awaddr, araddr, wdata} = 48'h0;
		{bready, rready} = 2'h0;
		gclk = 4'h0;
		wstrb = 4'hf;
		strb_sel = 4'hf;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_regs();
		t_ring();
		t_flash();
		t_stream();
		t_fifo();
		t_gclk();
		wrap_up();
	end
endmodule
